// ### verilog/uhb_pkg.sv
// Purpose: shared constants and types of the parallel host bus link
// Assumes: one 25 MHz clock on both ends, all pins synchronous to it
// Notes: the phase length is the least strobe width rounded up to cycles
package uhb_pkg;

	localparam int UHB_DW = 8;
	localparam int UHB_AW = 3;
	localparam int UHB_NREG = 8;

	localparam int UHB_CLK_PERIOD_NS = 40;
	localparam int UHB_STROBE_MIN_NS = 150;
	localparam int UHB_PHASE_CYC =
		(UHB_STROBE_MIN_NS + UHB_CLK_PERIOD_NS - 1) / UHB_CLK_PERIOD_NS;

	// Pin and storage values after reset
	localparam logic UHB_PIN_IDLE = 1'b1;
	localparam logic [7:0] UHB_REG_RST = 8'h00;
	localparam logic [7:0] UHB_BUS_PULL = 8'hff;

	// Bit positions of the register-select lines reused in muxed mode
	localparam int UHB_SEL_IR = 2;
	localparam int UHB_SEL_RS485 = 1;
	localparam int UHB_SEL_LATCH = 0;

	typedef enum logic [1:0] {
		UHB_MODE_DIR = 2'b00,
		UHB_MODE_STROBE = 2'b01,
		UHB_MODE_MUX = 2'b10
	} uhb_mode_t;

	typedef enum logic [1:0] {
		UHB_D_IDLE = 2'b00,
		UHB_D_READ = 2'b01,
		UHB_D_WRITE = 2'b10
	} uhb_dstate_t;

	typedef enum logic [2:0] {
		UHB_H_IDLE = 3'b000,
		UHB_H_ALE = 3'b001,
		UHB_H_ALE_HI = 3'b010,
		UHB_H_SETUP = 3'b011,
		UHB_H_STROBE = 3'b100,
		UHB_H_FINISH = 3'b101,
		UHB_H_RECOV = 3'b110
	} uhb_hstate_t;

endpackage : uhb_pkg

// ### verilog/uhb_bus_if.sv
// Purpose: pins between host processor and the device's host port
// Assumes: the data bus carries a pull-up, so an undriven bus reads all ones
// Notes: the resolved bus level is worked out here from the two enables
`timescale 1ns/1ps
interface uhb_bus_if;
	import uhb_pkg::*;

	logic mux_en;
	logic bus_style;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [UHB_AW-1:0] reg_sel;
	logic [UHB_DW-1:0] h_dout;
	logic h_doe;
	logic [UHB_DW-1:0] d_dout;
	logic d_doe;
	logic [UHB_DW-1:0] data;

	// A clash (both enables high) shows the device value; the checker flags it
	assign data = d_doe ? d_dout : (h_doe ? h_dout : UHB_BUS_PULL);

	modport host (
		output mux_en, bus_style, cs_n, rd_n, wr_n, reg_sel, h_dout, h_doe,
		input data
	);

	modport device (
		input mux_en, bus_style, cs_n, rd_n, wr_n, reg_sel, data,
		output d_dout, d_doe
	);

endinterface : uhb_bus_if

// ### verilog/uhb_host.sv
// Purpose: host processor end, turns one-cycle requests into pin cycles
// Assumes: mode inputs are held steady while o_req_ready is low
// Notes: every phase lasts the least strobe width; no overlap of phases
`timescale 1ns/1ps
module uhb_host
	import uhb_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	uhb_bus_if.host bus,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic [UHB_AW-1:0] i_req_index,
	input wire logic [UHB_DW-1:0] i_req_wdata,
	input wire logic i_muxed_bus_enable,
	input wire logic i_bus_style,
	input wire logic i_sleep_powerdown_n,
	input wire logic i_infrared_enable_n,
	input wire logic i_rs485_enable_n,
	output logic o_req_ready,
	output logic [UHB_DW-1:0] o_rd_data,
	output logic o_rd_valid
);

	typedef struct packed {
		uhb_hstate_t st;
		logic [2:0] cnt;
		logic write;
		logic [UHB_AW-1:0] idx;
		logic [UHB_DW-1:0] wdata;
		logic mux;
		logic style;
		logic ir_n;
		logic rs485_n;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [UHB_AW-1:0] sel;
		logic [UHB_DW-1:0] dout;
		logic doe;
		logic ready;
		logic [UHB_DW-1:0] rdata;
		logic rd_valid;
	} uhb_host_t;

	uhb_host_t s_q;
	uhb_host_t s_d;
	logic phase_done;
	logic dir_mode;

	////////////////////////////////////////////////////////////////////////////

	assign phase_done = (s_q.cnt == 3'h0);
	// Taken from inputs and state, not from s_d, so the next-state logic has no loop
	assign dir_mode = (s_q.st == UHB_H_IDLE) ? (!i_muxed_bus_enable && !i_bus_style)
		: (!s_q.mux && !s_q.style);

	always_comb
	begin
		s_d = s_q;
		s_d.rd_valid = 1'b0;
		if (s_q.cnt != 3'h0)
		begin
			s_d.cnt = s_q.cnt - 3'h1;
		end
		unique case (s_q.st)
			UHB_H_IDLE:
			begin
				s_d.mux = i_muxed_bus_enable;
				// Muxed mode reuses the style pin as the sleep control
				s_d.style = i_muxed_bus_enable ? i_sleep_powerdown_n : i_bus_style;
				s_d.ir_n = i_infrared_enable_n;
				s_d.rs485_n = i_rs485_enable_n;
				if (i_req_valid)
				begin
					s_d.write = i_req_write;
					s_d.idx = i_req_index;
					s_d.wdata = i_req_wdata;
					s_d.st = i_muxed_bus_enable ? UHB_H_ALE : UHB_H_SETUP;
				end
			end
			UHB_H_ALE: if (phase_done) s_d.st = UHB_H_ALE_HI;
			UHB_H_ALE_HI: if (phase_done) s_d.st = UHB_H_SETUP;
			UHB_H_SETUP: if (phase_done) s_d.st = UHB_H_STROBE;
			UHB_H_STROBE:
			if (phase_done)
			begin
				s_d.st = UHB_H_FINISH;
				if (!s_q.write)
				begin
					// Read byte taken on the edge that ends the strobe
					s_d.rdata = bus.data;
					s_d.rd_valid = 1'b1;
				end
			end
			UHB_H_FINISH: if (phase_done) s_d.st = UHB_H_RECOV;
			UHB_H_RECOV: if (phase_done) s_d.st = UHB_H_IDLE;
			default: s_d.st = UHB_H_IDLE;
		endcase
		if (s_d.st != s_q.st)
		begin
			s_d.cnt = 3'(UHB_PHASE_CYC - 1);
		end

		// Pins follow the next state so that they all leave flip-flops
		s_d.cs_n = UHB_PIN_IDLE;
		s_d.rd_n = UHB_PIN_IDLE; // Unused read strobe held high
		s_d.wr_n = UHB_PIN_IDLE;
		s_d.doe = 1'b0;
		s_d.dout = s_d.wdata;
		if (s_d.mux)
		begin
			s_d.sel[UHB_SEL_IR] = s_d.ir_n;
			s_d.sel[UHB_SEL_RS485] = s_d.rs485_n;
			s_d.sel[UHB_SEL_LATCH] = UHB_PIN_IDLE;
		end
		else
		begin
			s_d.sel = s_d.idx;
		end
		// Direction steady from setup to recovery, around the select
		if (dir_mode && s_d.st != UHB_H_IDLE)
		begin
			s_d.wr_n = !s_d.write;
		end
		unique case (s_d.st)
			UHB_H_ALE, UHB_H_ALE_HI:
			begin
				// Address on the shared lines, latch pulsed low then raised
				s_d.doe = 1'b1;
				s_d.dout = {{(UHB_DW - UHB_AW){1'b0}}, s_d.idx};
				s_d.sel[UHB_SEL_LATCH] = (s_d.st == UHB_H_ALE_HI);
			end
			UHB_H_SETUP:
			begin
				s_d.cs_n = dir_mode;
				s_d.doe = s_d.write;
			end
			UHB_H_STROBE:
			begin
				s_d.cs_n = 1'b0;
				s_d.doe = s_d.write;
				if (!dir_mode)
				begin
					s_d.wr_n = !s_d.write;
					s_d.rd_n = s_d.write;
				end
			end
			UHB_H_FINISH:
			begin
				// Data held past the rising strobe or select
				s_d.cs_n = dir_mode;
				s_d.doe = s_d.write;
			end
			default:
			begin
				s_d.doe = 1'b0;
			end
		endcase
		s_d.ready = (s_d.st == UHB_H_IDLE);
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			s_q <= '0;
			s_q.st <= UHB_H_IDLE;
			s_q.cs_n <= UHB_PIN_IDLE;
			s_q.rd_n <= UHB_PIN_IDLE;
			s_q.wr_n <= UHB_PIN_IDLE;
			s_q.sel <= {UHB_AW{UHB_PIN_IDLE}};
			s_q.style <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	assign bus.mux_en = s_q.mux;
	assign bus.bus_style = s_q.style;
	assign bus.cs_n = s_q.cs_n;
	assign bus.rd_n = s_q.rd_n;
	assign bus.wr_n = s_q.wr_n;
	assign bus.reg_sel = s_q.sel;
	assign bus.h_dout = s_q.dout;
	assign bus.h_doe = s_q.doe;
	assign o_req_ready = s_q.ready;
	assign o_rd_data = s_q.rdata;
	assign o_rd_valid = s_q.rd_valid;

endmodule : uhb_host

// ### verilog/uhb_device.sv
// Purpose: device end of the 8-bit parallel host port with its register bank
// Assumes: pins are synchronous to i_clk_sys; strobes last two cycles or more
// Notes: edges are found against last cycle's pin sample, so a pin change
//        is seen in the cycle it arrives and acted on one cycle later
//
// How it works
// - Mux low, style high: strobe bus
// - Mux low, style low: direction bus
// - Mux high: muxed mode, style pin is sleep
// - Three select lines pick the register
// - Muxed: selects become IR, RS485, latch
// - Bidirectional data, driven only on reads
// - Muxed: data lines carry address, then data
// - Read strobe fall fetches and drives byte
// - Host samples read byte at strobe rise
// - Direction mode: read strobe held high
// - Write strobe fall starts write cycle
// - Write strobe rise stores the data
// - Direction mode: write pin gives direction
// - Access only while chip select low
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module uhb_device
	import uhb_pkg::*;
#(
	parameter int NREG = UHB_NREG
)
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	uhb_bus_if.device bus,
	output logic o_wr_pulse,
	output logic [UHB_AW-1:0] o_wr_index,
	output logic [UHB_DW-1:0] o_wr_data,
	output logic o_rd_pulse,
	output logic [UHB_AW-1:0] o_rd_index,
	output logic [1:0] o_mode,
	output logic o_sleep_powerdown_n,
	output logic o_infrared_enable_n,
	output logic o_rs485_enable_n
);

	typedef struct packed {
		uhb_dstate_t st;
		uhb_mode_t mode;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic lat_n;
		logic [UHB_AW-1:0] idx;
		logic [UHB_AW-1:0] maddr;
		logic [UHB_DW-1:0] dout;
		logic doe;
		logic wr_pulse;
		logic [UHB_AW-1:0] wr_idx;
		logic [UHB_DW-1:0] wr_data;
		logic rd_pulse;
		logic [UHB_AW-1:0] rd_idx;
		logic sleep_n;
		logic ir_n;
		logic rs485_n;
		logic [NREG-1:0][UHB_DW-1:0] regs;
	} uhb_dev_t;

	uhb_dev_t s_q;
	uhb_dev_t s_d;
	uhb_mode_t mode_now;
	logic [UHB_AW-1:0] sel_now;
	logic selected;
	logic cs_fall;
	logic cs_rise;
	logic rd_fall;
	logic rd_rise;
	logic wr_fall;
	logic wr_rise;
	logic lat_rise;

	////////////////////////////////////////////////////////////////////////////
	// Mode decode and edge detection

	always_comb
	begin
		if (bus.mux_en)
		begin
			mode_now = UHB_MODE_MUX;
		end
		else if (bus.bus_style)
		begin
			mode_now = UHB_MODE_STROBE;
		end
		else
		begin
			mode_now = UHB_MODE_DIR;
		end
	end

	// In muxed mode the index comes from the latched address phase
	assign sel_now = (mode_now == UHB_MODE_MUX) ? s_q.maddr : bus.reg_sel;
	assign selected = !bus.cs_n;
	assign cs_fall = s_q.cs_n && !bus.cs_n;
	assign cs_rise = !s_q.cs_n && bus.cs_n;
	assign rd_fall = s_q.rd_n && !bus.rd_n;
	assign rd_rise = !s_q.rd_n && bus.rd_n;
	assign wr_fall = s_q.wr_n && !bus.wr_n;
	assign wr_rise = !s_q.wr_n && bus.wr_n;
	assign lat_rise = !s_q.lat_n && bus.reg_sel[UHB_SEL_LATCH];

	////////////////////////////////////////////////////////////////////////////
	// Transfer control

	always_comb
	begin
		s_d = s_q;
		s_d.wr_pulse = 1'b0;
		s_d.rd_pulse = 1'b0;
		s_d.cs_n = bus.cs_n;
		s_d.rd_n = bus.rd_n;
		s_d.wr_n = bus.wr_n;
		s_d.lat_n = bus.reg_sel[UHB_SEL_LATCH];
		s_d.mode = mode_now;

		if (mode_now == UHB_MODE_MUX)
		begin
			// Select lines and style pin take their muxed-mode meaning
			s_d.ir_n = bus.reg_sel[UHB_SEL_IR];
			s_d.rs485_n = bus.reg_sel[UHB_SEL_RS485];
			s_d.sleep_n = bus.bus_style;
			if (lat_rise)
			begin
				s_d.maddr = bus.data[UHB_AW-1:0];
			end
		end
		else
		begin
			s_d.ir_n = UHB_PIN_IDLE;
			s_d.rs485_n = UHB_PIN_IDLE;
			s_d.sleep_n = UHB_PIN_IDLE;
		end

		if (mode_now != s_q.mode)
		begin
			// A mode change mid-cycle drops the cycle rather than guess its end
			s_d.st = UHB_D_IDLE;
			s_d.doe = 1'b0;
		end
		else if (mode_now == UHB_MODE_DIR)
		begin
			unique case (s_q.st)
				UHB_D_IDLE:
				if (cs_fall)
				begin
					// Write pin read as direction at select fall
					s_d.idx = sel_now;
					if (bus.wr_n)
					begin
						s_d.st = UHB_D_READ;
						s_d.dout = s_q.regs[sel_now];
						s_d.doe = 1'b1;
						s_d.rd_pulse = 1'b1;
						s_d.rd_idx = sel_now;
					end
					else
					begin
						s_d.st = UHB_D_WRITE;
					end
				end
				UHB_D_READ:
				if (cs_rise)
				begin
					s_d.st = UHB_D_IDLE;
					s_d.doe = 1'b0;
				end
				UHB_D_WRITE:
				if (cs_rise)
				begin
					// Select rise ends the write and stores the byte
					s_d.st = UHB_D_IDLE;
					s_d.regs[s_q.idx] = bus.data;
					s_d.wr_pulse = 1'b1;
					s_d.wr_idx = s_q.idx;
					s_d.wr_data = bus.data;
				end
				default:
				begin
					s_d.st = UHB_D_IDLE;
					s_d.doe = 1'b0;
				end
			endcase
		end
		else
		begin
			// Strobe style, also the data phase of muxed mode
			unique case (s_q.st)
				UHB_D_IDLE:
				if (selected && rd_fall)
				begin
					s_d.st = UHB_D_READ;
					s_d.idx = sel_now;
					s_d.dout = s_q.regs[sel_now];
					s_d.doe = 1'b1;
					s_d.rd_pulse = 1'b1;
					s_d.rd_idx = sel_now;
				end
				else if (selected && wr_fall)
				begin
					s_d.st = UHB_D_WRITE;
					s_d.idx = sel_now;
				end
				UHB_D_READ:
				if (rd_rise || !selected)
				begin
					s_d.st = UHB_D_IDLE;
					s_d.doe = 1'b0;
				end
				UHB_D_WRITE:
				if (wr_rise)
				begin
					s_d.st = UHB_D_IDLE;
					s_d.regs[s_q.idx] = bus.data;
					s_d.wr_pulse = 1'b1;
					s_d.wr_idx = s_q.idx;
					s_d.wr_data = bus.data;
				end
				else if (!selected)
				begin
					// Select lost before the strobe rose: nothing is stored
					s_d.st = UHB_D_IDLE;
				end
				default:
				begin
					s_d.st = UHB_D_IDLE;
					s_d.doe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			s_q <= '0;
			s_q.st <= UHB_D_IDLE;
			s_q.mode <= UHB_MODE_STROBE;
			s_q.cs_n <= UHB_PIN_IDLE;
			s_q.rd_n <= UHB_PIN_IDLE;
			s_q.wr_n <= UHB_PIN_IDLE;
			s_q.lat_n <= UHB_PIN_IDLE;
			s_q.sleep_n <= UHB_PIN_IDLE;
			s_q.ir_n <= UHB_PIN_IDLE;
			s_q.rs485_n <= UHB_PIN_IDLE;
			s_q.regs <= {NREG{UHB_REG_RST}};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register

	assign bus.d_dout = s_q.dout;
	assign bus.d_doe = s_q.doe;
	assign o_wr_pulse = s_q.wr_pulse;
	assign o_wr_index = s_q.wr_idx;
	assign o_wr_data = s_q.wr_data;
	assign o_rd_pulse = s_q.rd_pulse;
	assign o_rd_index = s_q.rd_idx;
	assign o_mode = s_q.mode;
	assign o_sleep_powerdown_n = s_q.sleep_n;
	assign o_infrared_enable_n = s_q.ir_n;
	assign o_rs485_enable_n = s_q.rs485_n;

endmodule : uhb_device

// ### test/uhb_props.sv
// Purpose: pin-level checks on the link between host and device ends
// Assumes: one clock, synchronous active high reset
// Notes: both ends are design code, so every pin here is design driven
`timescale 1ns/1ps
module uhb_props
	import uhb_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic mux_en,
	input wire logic bus_style,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [UHB_AW-1:0] reg_sel,
	input wire logic h_doe,
	input wire logic d_doe
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////////////////////////
	wire logic strb = !mux_en && bus_style;
	wire logic dirm = !mux_en && !bus_style;

	a_no_clash: assert property (!(d_doe && h_doe))
		else $error("bus driven by both ends");
	a_read_drive: assert property (strb && $fell(rd_n) && !cs_n |-> ##[1:2] d_doe)
		else $error("read strobe did not get the bus driven");
	a_read_release: assert property (strb && $rose(rd_n) |-> ##[1:2] !d_doe)
		else $error("bus held after read strobe ended");
	a_write_quiet: assert property (!wr_n |-> !d_doe)
		else $error("device drives bus during a write");
	a_drive_in_cs: assert property (d_doe |-> !cs_n || !$past(cs_n) || !$past(cs_n, 2))
		else $error("device drives bus without chip select");
	a_dir_rd_idle: assert property (dirm |-> rd_n)
		else $error("read strobe active in direction mode");
	a_dir_stable: assert property (dirm && !cs_n && !$past(cs_n) |-> $stable(wr_n))
		else $error("direction changed inside chip select");
	a_latch_addr: assert property (mux_en && $stable(mux_en) && $fell(reg_sel[UHB_SEL_LATCH])
		|-> h_doe && rd_n && wr_n)
		else $error("address latch without address on bus");
	a_wr_width: assert property (strb && $fell(wr_n) |-> !wr_n [*4])
		else $error("write strobe shorter than its phase");
	a_strobe_cs: assert property (strb && (!rd_n || !wr_n) |-> !cs_n)
		else $error("strobe outside chip select");

	c_strobe_read: cover property (strb && $fell(rd_n));
	c_dir_write: cover property (dirm && $fell(cs_n) && !wr_n);
	c_mux_latch: cover property (mux_en && $fell(reg_sel[UHB_SEL_LATCH]));
endmodule : uhb_props

// ### test/uart_host_bus_interface_tb.sv
// Purpose: self-checking bench of host and device ends joined by the link
// Assumes: 25 MHz clock, synchronous active high reset held three cycles
// Notes: an array mirrors the register bank so read data is predicted
`timescale 1ns/1ps
module uart_host_bus_interface_tb;
	import uhb_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [2:0] req_index = 3'h0;
	logic [7:0] req_wdata = 8'h00;
	logic mux_en = 1'b0;
	logic style = 1'b1;
	logic sleep_n = 1'b1;
	logic ir_n = 1'b1;
	logic rs_n = 1'b1;
	logic req_ready, rd_valid, wr_pulse, rd_pulse, sleep_o, ir_o, rs_o;
	logic [7:0] rd_data, wr_data, wire_rd;
	logic [2:0] wr_index, rd_index;
	logic [1:0] mode;
	logic [7:0] mdl [8] = '{default: 8'h00};
	int n_rd = 0;
	int n_rv = 0;
	int n_wr = 0;
	int n_fail = 0;
	int total_checks = 0;

	always #20 i_clk_sys = ~i_clk_sys;
	////////////////////////////////////////////////////////////
	uhb_bus_if bus ();
	uhb_host uhb_host_inst (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .bus(bus),
		.i_req_valid(req_valid), .i_req_write(req_write), .i_req_index(req_index),
		.i_req_wdata(req_wdata), .i_muxed_bus_enable(mux_en), .i_bus_style(style),
		.i_sleep_powerdown_n(sleep_n), .i_infrared_enable_n(ir_n), .i_rs485_enable_n(rs_n),
		.o_req_ready(req_ready), .o_rd_data(rd_data), .o_rd_valid(rd_valid));
	uhb_device uhb_device_inst (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .bus(bus),
		.o_wr_pulse(wr_pulse), .o_wr_index(wr_index), .o_wr_data(wr_data),
		.o_rd_pulse(rd_pulse), .o_rd_index(rd_index), .o_mode(mode),
		.o_sleep_powerdown_n(sleep_o), .o_infrared_enable_n(ir_o), .o_rs485_enable_n(rs_o));
	uhb_props uhb_props_inst (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.mux_en(bus.mux_en), .bus_style(bus.bus_style), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
		.wr_n(bus.wr_n), .reg_sel(bus.reg_sel), .h_doe(bus.h_doe), .d_doe(bus.d_doe));

	// Byte seen on the wire while the device owns it
	always @(posedge i_clk_sys)
	begin
		if (bus.d_doe === 1'b1 && bus.cs_n === 1'b0)
			wire_rd <= bus.data;
		if (rd_pulse === 1'b1)
			n_rd++;
		if (rd_valid === 1'b1)
			n_rv++;
		if (wr_pulse === 1'b1)
			n_wr++;
	end
	////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_ready();
		int n;
		n = 0;
		while (req_ready !== 1'b1)
		begin
			@(posedge i_clk_sys);
			n++;
			if (n > 60)
			begin
				n_fail++;
				wrap_up();
			end
		end
	endtask : wait_ready

	task automatic xfer(input logic w, input logic [2:0] ix, input logic [7:0] wd);
		wait_ready();
		req_valid <= 1'b1;
		req_write <= w;
		req_index <= ix;
		req_wdata <= wd;
		@(posedge i_clk_sys);
		req_valid <= 1'b0;
		@(posedge i_clk_sys);
		wait_ready();
		if (w)
			mdl[ix] = wd;
	endtask : xfer

	task automatic rd_chk(input logic [2:0] ix);
		xfer(1'b0, ix, 8'h00);
		chk(rd_data, mdl[ix]);
		chk(wire_rd, mdl[ix]);
		chk({5'h00, rd_index}, {5'h00, ix});
	endtask : rd_chk

	// Mode pins only move while the host is idle
	task automatic set_mode(input logic m, input logic s);
		mux_en <= m;
		style <= s;
		repeat (4) @(posedge i_clk_sys);
	endtask : set_mode

	// Fill every register back to back, then read all of them in reverse
	task automatic sweep(input logic [7:0] seed);
		int b_rd;
		int b_rv;
		int b_wr;
		b_wr = n_wr;
		for (int i = 0; i < 8; i++)
			xfer(1'b1, 3'(i), seed + 8'(i * 37));
		chk(8'(n_wr - b_wr), 8'h08);
		chk(wr_data, seed + 8'(7 * 37));
		chk({5'h00, wr_index}, 8'h07);
		b_rd = n_rd;
		b_rv = n_rv;
		for (int i = 7; i >= 0; i--)
			rd_chk(3'(i));
		chk(8'(n_rd - b_rd), 8'h08);
		chk(8'(n_rv - b_rv), 8'h08);
	endtask : sweep
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({6'h00, mode}, 8'(UHB_MODE_STROBE));
		chk(bus.data, UHB_BUS_PULL);
		rd_chk(3'h6);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_strobe();
		set_mode(1'b0, 1'b1);
		chk({6'h00, mode}, 8'(UHB_MODE_STROBE));
		sweep(8'h5a);
		$display("t_strobe done");
	endtask : t_strobe

	task automatic t_dir();
		set_mode(1'b0, 1'b0);
		chk({6'h00, mode}, 8'(UHB_MODE_DIR));
		rd_chk(3'h3);
		sweep(8'hc3);
		$display("t_dir done");
	endtask : t_dir

	task automatic t_mux();
		sleep_n <= 1'b0;
		ir_n <= 1'b0;
		set_mode(1'b1, 1'b1);
		chk({6'h00, mode}, 8'(UHB_MODE_MUX));
		chk({7'h00, sleep_o}, 8'h00);
		chk({6'h00, ir_o, rs_o}, 8'h01);
		sleep_n <= 1'b1;
		ir_n <= 1'b1;
		rs_n <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		chk({5'h00, sleep_o, ir_o, rs_o}, 8'h06);
		rs_n <= 1'b1;
		sweep(8'h96);
		$display("t_mux done");
	endtask : t_mux

	// Leaving muxed mode keeps the bank and frees the reused pins
	task automatic t_back();
		set_mode(1'b0, 1'b1);
		chk({5'h00, sleep_o, ir_o, rs_o}, 8'h07);
		rd_chk(3'h2);
		$display("t_back done");
	endtask : t_back

	initial
	begin
		repeat (3) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		@(posedge i_clk_sys);
		t_reset();
		t_strobe();
		t_dir();
		t_mux();
		t_back();
		wrap_up();
	end
endmodule : uart_host_bus_interface_tb
